// ---- pkg/valve_health_cfg.svh ----
// Timing, threshold and alert bit position constants for the valve health monitor
`ifndef VALVE_HEALTH_CFG_SVH
`define VALVE_HEALTH_CFG_SVH

// Percent values use 0.01 % steps, 10000 = full travel
`define VH_CLK_NS 10
`define VH_SEC_NS 1000000000
`define VH_SEC_PER_HOUR 12'hE10
`define VH_TSO_IDLE_SEC 12'h4B0
`define VH_SUSPEND_SEC 3'h5
`define VH_NEAR_SP 16'h0064
`define VH_SPRING_COVER 16'h0384
`define VH_STOP_LO 16'h00C8
`define VH_STOP_HI 16'h2648
`define VH_MOVE_MIN 16'h000A
`define VH_MOVE_MAX 16'h01F4
`define VH_JUMP_MIN 16'h0032
`define VH_SMOOTH_MAX 16'h0014
`define VH_LARGE_STEP 16'h01F4

`define VH_A_FRIC_LO 0
`define VH_A_FRIC_HI 1
`define VH_A_ERROR 2
`define VH_A_OFFSET 3
`define VH_A_STICK 4
`define VH_A_POS_RATE 5
`define VH_A_SP_RATE 6
`define VH_A_TSO_RATE 7

`endif

// ---- pkg/valve_health_pkg.sv ----
// Types shared by the valve health monitor
package valve_health_pkg;
   typedef enum logic [1:0] {
      TSO_OPEN = 2'b01,
      TSO_SHUT = 2'b10
   } tso_state_t;
endpackage : valve_health_pkg

// ---- rtl/valve_health_alert_monitor.sv ----
// Valve health indicators with per-alert enable, mask and limit
`timescale 1ns/1ps
`include "valve_health_cfg.svh"

// Overview of operation
// - Every alert has its own enable, its own reporting mask and its own limit input.
// - Reported alert bits are returned on each additional-status request.
// - Latest indicator values are always readable as plain outputs, with no history.
// - Friction is only computed from in-band moves that are neither tiny nor huge.
// - Friction is checked hourly, on any limit access and when a signature test ends.
// - Lower spring is the pressure where motion starts, upper where travel peaks.
// - Spring range is published hourly only once nine percent of travel was covered.
// - Stick slip is smooth setpoint with a jumping position, with an amplitude.
// - Setpoint and position cycles are abrupt reversals, with a step of at least the stick slip jump size.
// - Error is the absolute and offset the signed position minus setpoint.
// - After a large setpoint step error is frozen until within 1 % or 5 s.
// - Error and offset update continuously and are checked once an hour.
// - Shutoff mode enters below threshold, exits above threshold plus deadband, one cycle.
// - Every shutoff cycle bumps a counter and the hourly count becomes the rate.
// - Twenty minutes without a shutoff cycle force the shutoff rate to zero.
module valve_health_alert_monitor
   import valve_health_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `VH_SEC_NS / `VH_CLK_NS
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic sample_valid,
   input wire logic [15:0] setpoint,
   input wire logic [15:0] position,
   input wire logic [15:0] pressure,
   input wire logic [15:0] tso_threshold,
   input wire logic [15:0] tso_deadband,
   input wire logic limit_access,
   input wire logic signature_done,
   input wire logic status_req,
   input wire logic [7:0] alert_enable,
   input wire logic [7:0] alert_mask,
   input wire logic [15:0] lim_friction_low,
   input wire logic [15:0] lim_friction_high,
   input wire logic [15:0] lim_error,
   input wire logic [15:0] lim_offset,
   input wire logic [15:0] lim_stick_amp,
   input wire logic [15:0] lim_pos_rate,
   input wire logic [15:0] lim_sp_rate,
   input wire logic [15:0] lim_tso_rate,
   output logic [7:0] status_byte_q,
   output logic status_valid_q,
   output logic [15:0] friction_q,
   output logic [15:0] spring_lower_q,
   output logic [15:0] spring_upper_q,
   output logic spring_valid_q,
   output logic stick_flag_q,
   output logic [15:0] stick_amp_q,
   output logic [15:0] error_q,
   output logic signed [16:0] offset_q,
   output logic [15:0] sp_rate_q,
   output logic [15:0] pos_rate_q,
   output logic [15:0] tso_count_q,
   output logic [15:0] tso_rate_q,
   output logic tso_active_q
);

   function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
      return (a > b) ? a - b : b - a;
   endfunction : absdiff

   function automatic logic [15:0] inc16(input logic [15:0] a);
      return (a == 16'hFFFF) ? a : a + 16'h0001;
   endfunction : inc16

   // ********************************************
   // Time base
   // ********************************************
   logic [31:0] tick_q;
   logic [11:0] sec_q;
   wire sec_pulse = (tick_q == SEC_CYCLES - 1);
   wire hour_pulse = sec_pulse && (sec_q == `VH_SEC_PER_HOUR - 12'h001);

   always_ff @(posedge clk) begin
      if (srst || sec_pulse) tick_q <= '0;
      else tick_q <= tick_q + 32'd1;
      if (srst || hour_pulse) sec_q <= '0;
      else if (sec_pulse) sec_q <= sec_q + 12'h001;
   end

   // ********************************************
   // Sample decoding
   // ********************************************
   logic [15:0] prev_sp_q, prev_pos_q;
   logic have_prev_q;
   wire [15:0] adpos = absdiff(position, prev_pos_q);
   wire [15:0] adsp = absdiff(setpoint, prev_sp_q);
   wire new_sample = sample_valid && have_prev_q;
   wire in_band = (position > `VH_STOP_LO) && (position < `VH_STOP_HI);
   wire fric_move = new_sample && in_band && adpos >= `VH_MOVE_MIN
      && adpos <= `VH_MOVE_MAX;
   wire pos_up = position > prev_pos_q;
   wire sp_up = setpoint > prev_sp_q;
   wire pos_move = new_sample && in_band && adpos >= `VH_MOVE_MIN;
   wire sp_move = new_sample && in_band && adsp >= `VH_MOVE_MIN;
   wire stick_evt = new_sample && in_band && adsp <= `VH_SMOOTH_MAX
      && adpos >= `VH_JUMP_MIN;

   always_ff @(posedge clk) begin
      if (srst) begin
         prev_sp_q <= '0;
         prev_pos_q <= '0;
         have_prev_q <= 1'b0;
      end else if (sample_valid) begin
         prev_sp_q <= setpoint;
         prev_pos_q <= position;
         have_prev_q <= 1'b1;
      end
   end

   // ********************************************
   // Friction and spring range
   // ********************************************
   // Hysteresis estimate: half the pressure gap between opening and closing moves
   logic [15:0] p_up_q, p_dn_q, sr_lo_q, sr_hi_q, cov_lo_q, cov_hi_q;
   logic seen_up_q, seen_dn_q;
   wire [15:0] p_up_d = pos_up ? pressure : p_up_q;
   wire [15:0] p_dn_d = pos_up ? p_dn_q : pressure;
   wire both_seen = (seen_up_q || pos_up) && (seen_dn_q || !pos_up);
   wire [15:0] coverage = (cov_hi_q > cov_lo_q) ? cov_hi_q - cov_lo_q : 16'h0000;

   always_ff @(posedge clk) begin
      if (srst) begin
         p_up_q <= '0;
         p_dn_q <= '0;
         seen_up_q <= 1'b0;
         seen_dn_q <= 1'b0;
         friction_q <= '0;
      end else if (fric_move) begin
         p_up_q <= p_up_d;
         p_dn_q <= p_dn_d;
         seen_up_q <= seen_up_q || pos_up;
         seen_dn_q <= seen_dn_q || !pos_up;
         if (both_seen) friction_q <= absdiff(p_up_d, p_dn_d) >> 1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst || hour_pulse) begin
         sr_lo_q <= 16'hFFFF;
         sr_hi_q <= '0;
         cov_lo_q <= 16'hFFFF;
         cov_hi_q <= '0;
      end else if (fric_move && pos_up) begin
         if (pressure < sr_lo_q) sr_lo_q <= pressure;
         if (pressure > sr_hi_q) sr_hi_q <= pressure;
         if (prev_pos_q < cov_lo_q) cov_lo_q <= prev_pos_q;
         if (position > cov_hi_q) cov_hi_q <= position;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         spring_lower_q <= '0;
         spring_upper_q <= '0;
         spring_valid_q <= 1'b0;
      end else if (hour_pulse && coverage >= `VH_SPRING_COVER) begin
         spring_lower_q <= sr_lo_q;
         spring_upper_q <= sr_hi_q;
         spring_valid_q <= 1'b1;
      end
   end

   // ********************************************
   // Stick slip and cycling
   // ********************************************
   logic sp_dir_q, pos_dir_q, sp_dir_ok_q, pos_dir_ok_q;
   logic [15:0] sp_cyc_q, pos_cyc_q;
   wire sp_cycle = sp_move && sp_dir_ok_q && (sp_up != sp_dir_q) && adsp >= `VH_JUMP_MIN;
   wire pos_cycle = pos_move && pos_dir_ok_q && (pos_up != pos_dir_q)
      && adpos >= `VH_JUMP_MIN;

   // An event on the hour edge opens the new window instead of being lost
   always_ff @(posedge clk) begin
      if (srst) begin
         stick_flag_q <= 1'b0;
         stick_amp_q <= '0;
      end else if (hour_pulse) begin
         stick_flag_q <= stick_evt;
         stick_amp_q <= stick_evt ? adpos : 16'h0000;
      end else if (stick_evt) begin
         stick_flag_q <= 1'b1;
         if (adpos > stick_amp_q) stick_amp_q <= adpos;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         sp_dir_q <= 1'b0;
         pos_dir_q <= 1'b0;
         sp_dir_ok_q <= 1'b0;
         pos_dir_ok_q <= 1'b0;
         sp_cyc_q <= '0;
         pos_cyc_q <= '0;
         sp_rate_q <= '0;
         pos_rate_q <= '0;
      end else begin
         if (sp_move) begin
            sp_dir_q <= sp_up;
            sp_dir_ok_q <= 1'b1;
         end
         if (pos_move) begin
            pos_dir_q <= pos_up;
            pos_dir_ok_q <= 1'b1;
         end
         if (hour_pulse) begin
            sp_rate_q <= sp_cyc_q;
            pos_rate_q <= pos_cyc_q;
            sp_cyc_q <= sp_cycle ? 16'h0001 : 16'h0000;
            pos_cyc_q <= pos_cycle ? 16'h0001 : 16'h0000;
         end else begin
            if (sp_cycle) sp_cyc_q <= inc16(sp_cyc_q);
            if (pos_cycle) pos_cyc_q <= inc16(pos_cyc_q);
         end
      end
   end

   // ********************************************
   // Error and offset
   // ********************************************
   logic suspend_q;
   logic [2:0] sus_sec_q;
   wire [15:0] err_now = absdiff(setpoint, position);
   wire signed [16:0] off_now = $signed({1'b0, position}) - $signed({1'b0, setpoint});
   wire sus_end = suspend_q && sample_valid && err_now <= `VH_NEAR_SP
      || suspend_q && sus_sec_q >= `VH_SUSPEND_SEC;

   always_ff @(posedge clk) begin
      if (srst) begin
         suspend_q <= 1'b0;
         sus_sec_q <= '0;
         error_q <= '0;
         offset_q <= '0;
      end else if (new_sample && adsp >= `VH_LARGE_STEP) begin
         suspend_q <= 1'b1;
         sus_sec_q <= '0;
      end else if (sus_end) begin
         suspend_q <= 1'b0;
         if (sample_valid) begin
            error_q <= err_now;
            offset_q <= off_now;
         end
      end else if (suspend_q) begin
         if (sec_pulse) sus_sec_q <= sus_sec_q + 3'h1;
      end else if (sample_valid) begin
         error_q <= err_now;
         offset_q <= off_now;
      end
   end

   // ********************************************
   // Tight shutoff cycling
   // ********************************************
   tso_state_t tso_q;
   logic [15:0] tso_hour_q;
   logic [11:0] idle_sec_q;
   wire [16:0] tso_exit_lvl = {1'b0, tso_threshold} + {1'b0, tso_deadband};
   wire tso_enter = sample_valid && tso_q == TSO_OPEN && setpoint < tso_threshold;
   wire tso_exit = sample_valid && tso_q == TSO_SHUT && {1'b0, setpoint} > tso_exit_lvl;
   wire idle_done = idle_sec_q >= `VH_TSO_IDLE_SEC;

   always_ff @(posedge clk) begin
      if (srst) tso_q <= TSO_OPEN;
      else if (tso_enter) tso_q <= TSO_SHUT;
      else if (tso_exit) tso_q <= TSO_OPEN;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         tso_count_q <= '0;
         tso_hour_q <= '0;
         tso_rate_q <= '0;
         idle_sec_q <= '0;
         tso_active_q <= 1'b0;
      end else begin
         tso_active_q <= (tso_q == TSO_SHUT);
         if (tso_exit) tso_count_q <= inc16(tso_count_q);
         if (tso_exit) idle_sec_q <= '0;
         else if (sec_pulse && !idle_done) idle_sec_q <= idle_sec_q + 12'h001;
         if (hour_pulse) tso_hour_q <= tso_exit ? 16'h0001 : 16'h0000;
         else if (tso_exit) tso_hour_q <= inc16(tso_hour_q);
         if (idle_done && !tso_exit) tso_rate_q <= '0;
         else if (hour_pulse) tso_rate_q <= tso_hour_q;
      end
   end

   // ********************************************
   // Alert evaluation and status
   // ********************************************
   logic [7:0] alert_q;
   wire fric_check = hour_pulse || limit_access || signature_done;
   wire [15:0] off_mag = offset_q[16] ? 16'(-offset_q) : offset_q[15:0];
   wire [7:0] beyond = {tso_rate_q > lim_tso_rate, sp_rate_q > lim_sp_rate,
      pos_rate_q > lim_pos_rate, stick_amp_q > lim_stick_amp, off_mag > lim_offset,
      error_q > lim_error, friction_q > lim_friction_high,
      friction_q < lim_friction_low};
   wire [7:0] check = {{6{hour_pulse}}, {2{fric_check}}};
   wire [7:0] reported = alert_q & alert_enable & ~alert_mask;

   always_ff @(posedge clk) begin
      if (srst) begin
         alert_q <= '0;
         status_byte_q <= '0;
         status_valid_q <= 1'b0;
      end else begin
         alert_q <= (alert_q & ~check) | (check & beyond & alert_enable);
         status_valid_q <= status_req;
         if (status_req) status_byte_q <= reported;
      end
   end

   chk_status_masked: assert property (@(posedge clk) disable iff (srst)
      status_valid_q |-> (status_byte_q & $past(alert_mask | ~alert_enable)) == 8'h00)
      else $error("masked alert reported");
   chk_status_req: assert property (@(posedge clk) disable iff (srst)
      status_req |=> status_valid_q && status_byte_q == $past(reported))
      else $error("status answer wrong");
   chk_alert_hold: assert property (@(posedge clk) disable iff (srst)
      !hour_pulse && !fric_check |=> alert_q == $past(alert_q))
      else $error("alert changed outside a check");
   chk_friction_move: assert property (@(posedge clk) disable iff (srst)
      !fric_move |=> $stable(friction_q))
      else $error("friction changed without valid move");
   chk_spring_cover: assert property (@(posedge clk) disable iff (srst)
      $rose(spring_valid_q) |-> $past(hour_pulse) && $past(coverage) >= `VH_SPRING_COVER)
      else $error("spring published too early");
   chk_suspend_time: assert property (@(posedge clk) disable iff (srst)
      sus_sec_q <= `VH_SUSPEND_SEC)
      else $error("suspend outlived five seconds");
   chk_error_frozen: assert property (@(posedge clk) disable iff (srst)
      suspend_q && !sus_end |=> $stable(error_q) && $stable(offset_q))
      else $error("error moved while suspended");
   chk_tso_count: assert property (@(posedge clk) disable iff (srst)
      tso_exit && tso_count_q != 16'hFFFF |=> tso_count_q == $past(tso_count_q) + 16'h0001)
      else $error("shutoff cycle not counted");
   chk_tso_idle: assert property (@(posedge clk) disable iff (srst)
      idle_done && !tso_exit |=> tso_rate_q == 16'h0000)
      else $error("shutoff rate not cleared");
   chk_tso_enter: assert property (@(posedge clk) disable iff (srst)
      tso_enter |=> tso_q == TSO_SHUT ##1 tso_active_q)
      else $error("shutoff mode not entered");
endmodule : valve_health_alert_monitor

// ---- dv/hart_host_model.sv ----
// Host model that configures alert limits and polls the alert status
`timescale 1ns/1ps
module hart_host_model (
   input wire logic clk,
   input wire logic [7:0] status_byte_q,
   input wire logic status_valid_q,
   output logic limit_access,
   output logic signature_done,
   output logic status_req,
   output logic [7:0] alert_enable,
   output logic [7:0] alert_mask,
   output logic [15:0] lim_friction_low,
   output logic [15:0] lim_friction_high,
   output logic [15:0] lim_error,
   output logic [15:0] lim_offset,
   output logic [15:0] lim_stick_amp,
   output logic [15:0] lim_pos_rate,
   output logic [15:0] lim_sp_rate,
   output logic [15:0] lim_tso_rate
);
   initial begin
      {limit_access, signature_done, status_req} = 3'h0;
      alert_enable = 8'h06;
      alert_mask = 8'h00;
      lim_friction_low = 16'h0000;
      {lim_friction_high, lim_stick_amp, lim_pos_rate} = {3{16'hFFFF}};
      {lim_sp_rate, lim_tso_rate} = {2{16'hFFFF}};
      {lim_error, lim_offset} = {2{16'h01F4}};
   end
   // ****************************************
   // Host transactions
   // ****************************************
   // A quiet write models a limit change the device has not been told about
   task automatic write_fric_high(input logic [15:0] val, input logic announce);
      @(posedge clk);
      lim_friction_high <= val;
      limit_access <= announce;
      @(posedge clk);
      limit_access <= 1'b0;
   endtask : write_fric_high
   task automatic end_signature();
      @(posedge clk);
      signature_done <= 1'b1;
      @(posedge clk);
      signature_done <= 1'b0;
   endtask : end_signature
   task automatic set_mask(input logic [7:0] val);
      @(posedge clk);
      alert_mask <= val;
   endtask : set_mask
   // Answer is awaited a few cycles only, a missing pulse shows as got low
   task automatic read_status(output logic [7:0] seen, output logic got);
      @(posedge clk);
      status_req <= 1'b1;
      @(posedge clk);
      status_req <= 1'b0;
      #1;
      for (int i = 0; i < 4; i++) begin
         if (status_valid_q === 1'b1) break;
         @(posedge clk);
         #1;
      end
      got = status_valid_q;
      seen = status_byte_q;
   endtask : read_status
endmodule : hart_host_model

// ---- dv/testbench.sv ----
// Self-checking bench for the valve health alert monitor
`timescale 1ns/1ps
module testbench;
   localparam int HOUR = 36000;
   logic clk = 1'b0, srst = 1'b1, sample_valid = 1'b0;
   logic [15:0] setpoint = 16'h0000, position = 16'h0000, pressure = 16'h0000;
   logic [15:0] tso_threshold = 16'h03E8, tso_deadband = 16'h00C8;
   wire logic limit_access, signature_done, status_req, status_valid_q;
   wire logic [7:0] alert_enable, alert_mask, status_byte_q;
   wire logic [15:0] lim_friction_low, lim_friction_high, lim_error, lim_offset;
   wire logic [15:0] lim_stick_amp, lim_pos_rate, lim_sp_rate, lim_tso_rate;
   wire logic spring_valid_q, stick_flag_q, tso_active_q;
   wire logic [15:0] friction_q, error_q, tso_count_q, tso_rate_q;
   wire logic [15:0] spring_lower_q, spring_upper_q, stick_amp_q, sp_rate_q, pos_rate_q;
   wire logic signed [16:0] offset_q;
   int err_total = 0, n_compared = 0, cyc = 0;
   logic [7:0] st;
   logic got;
   always #5 clk = ~clk;
   always @(posedge clk) cyc <= srst ? 0 : cyc + 1;
   valve_health_alert_monitor #(.SEC_CYCLES(10)) i_valve_health_alert_monitor (.clk, .srst,
      .sample_valid, .setpoint, .position, .pressure, .tso_threshold, .tso_deadband,
      .limit_access, .signature_done, .status_req, .alert_enable, .alert_mask,
      .lim_friction_low, .lim_friction_high, .lim_error, .lim_offset, .lim_stick_amp,
      .lim_pos_rate, .lim_sp_rate, .lim_tso_rate, .status_byte_q, .status_valid_q,
      .friction_q, .spring_lower_q, .spring_upper_q, .spring_valid_q, .stick_flag_q,
      .stick_amp_q, .error_q, .offset_q, .sp_rate_q, .pos_rate_q, .tso_count_q,
      .tso_rate_q, .tso_active_q);
   hart_host_model i_hart_host_model (.clk, .status_byte_q, .status_valid_q, .limit_access,
      .signature_done, .status_req, .alert_enable, .alert_mask, .lim_friction_low,
      .lim_friction_high, .lim_error, .lim_offset, .lim_stick_amp, .lim_pos_rate,
      .lim_sp_rate, .lim_tso_rate);
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic smp(input logic [15:0] sp, input logic [15:0] pos, input logic [15:0] pr);
      @(posedge clk);
      setpoint <= sp;
      position <= pos;
      pressure <= pr;
      sample_valid <= 1'b1;
      @(posedge clk);
      sample_valid <= 1'b0;
      @(posedge clk);
      #1;
   endtask : smp
   task automatic status(input logic [7:0] exp);
      i_hart_host_model.read_status(st, got);
      check(32'(got), 32'h1);
      check(32'(st), 32'(exp));
   endtask : status
   task automatic err_off(input logic [15:0] e, input logic [31:0] o);
      check(32'(error_q), 32'(e));
      check(32'(offset_q), o);
   endtask : err_off
   task automatic wait_cyc(input int n);
      while (cyc < n) @(posedge clk);
      #1;
   endtask : wait_cyc
   task automatic print_verdict();
      if (err_total == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : print_verdict
   // Generous margin over two simulated hours
   initial begin
      repeat (80000) @(posedge clk);
      err_total++;
      print_verdict();
   end
   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      repeat (8) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      check(32'(error_q), 32'h0);
      check(32'(status_byte_q), 32'h0);
      smp(16'h1388, 16'h1388, 16'h09C4);
      smp(16'h1388, 16'h13EC, 16'h0BB8);
      check(32'(stick_flag_q), 32'h1);
      check(32'(stick_amp_q), 32'h0064);
      smp(16'h1388, 16'h1388, 16'h07D0);
      check(32'(friction_q), 32'h01F4);
      smp(16'h1388, 16'h15E0, 16'h2328);
      smp(16'h1388, 16'h1388, 16'h2328);
      check(32'(friction_q), 32'h01F4);
      i_hart_host_model.write_fric_high(16'h0064, 1'b1);
      status(8'h02);
      i_hart_host_model.write_fric_high(16'hFFFF, 1'b0);
      status(8'h02);
      i_hart_host_model.end_signature();
      status(8'h00);
      smp(16'h1388, 16'h1194, 16'h0000);
      err_off(16'h01F4, 32'hFFFFFE0C);
      smp(16'h13EC, 16'h1388, 16'h0000);
      err_off(16'h0064, 32'hFFFFFF9C);
      smp(16'h1F40, 16'h1388, 16'h0000);
      err_off(16'h0064, 32'hFFFFFF9C);
      repeat (80) @(posedge clk);
      smp(16'h1F40, 16'h1388, 16'h0000);
      err_off(16'h0BB8, 32'hFFFFF448);
      smp(16'h01F4, 16'h1388, 16'h0000);
      check(32'(tso_active_q), 32'h1);
      smp(16'h044C, 16'h1388, 16'h0000);
      check(32'({tso_active_q, tso_count_q}), 32'h10000);
      smp(16'h0514, 16'h1388, 16'h0000);
      check(32'({tso_active_q, tso_count_q}), 32'h00001);
      smp(16'h1770, 16'h1388, 16'h0000);
      repeat (80) @(posedge clk);
      smp(16'h1770, 16'h1388, 16'h0000);
      err_off(16'h03E8, 32'hFFFFFC18);
      wait_cyc(HOUR + 100);
      check(32'(stick_flag_q), 32'h0);
      check(32'(spring_valid_q), 32'h0);
      check(32'(sp_rate_q), 32'h2);
      check(32'(pos_rate_q), 32'h4);
      check(32'(tso_rate_q), 32'h0);
      status(8'h04);
      i_hart_host_model.set_mask(8'h04);
      status(8'h00);
      i_hart_host_model.set_mask(8'h00);
      smp(16'h1388, 16'h0BB8, 16'h03E8);
      smp(16'h1388, 16'h0D48, 16'h05DC);
      smp(16'h1388, 16'h0ED8, 16'h07D0);
      smp(16'h1388, 16'h1068, 16'h09C4);
      wait_cyc(HOUR + 30000);
      smp(16'h01F4, 16'h1388, 16'h0000);
      smp(16'h0514, 16'h1388, 16'h0000);
      check(32'(tso_count_q), 32'h2);
      wait_cyc(2 * HOUR + 100);
      check(32'(tso_rate_q), 32'h1);
      check(32'(spring_valid_q), 32'h1);
      check(32'(spring_lower_q), 32'h05DC);
      check(32'(spring_upper_q), 32'h09C4);
      // Large step freezes error, a sample within 1 % releases it at once
      smp(16'h0BB8, 16'h1388, 16'h0000);
      err_off(16'h03E8, 32'hFFFFFC18);
      smp(16'h0BB8, 16'h0BEA, 16'h0000);
      err_off(16'h0032, 32'h00000032);
      print_verdict();
   end
endmodule : testbench
